// >>> iox_pkg.sv
// Purpose: Shared constants and types for the serial 16-bit I/O expander.
// Assumes: Register selectors are three bits wide; each port is eight pins.
// Notes:   Register offsets, the latch, inversion, direction and pointer reset values and the byte bit count live here.
`default_nettype none
package iox_pkg;
  localparam int          PORT_WIDTH       = 8;
  localparam logic [3:0]  TARGET_PREFIX    = 4'h4;
  localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
  localparam logic [2:0]  SEL_IN_PORT0     = 3'h0;
  localparam logic [2:0]  SEL_IN_PORT1     = 3'h1;
  localparam logic [2:0]  SEL_OUT_PORT0    = 3'h2;
  localparam logic [2:0]  SEL_OUT_PORT1    = 3'h3;
  localparam logic [2:0]  SEL_INV_PORT0    = 3'h4;
  localparam logic [2:0]  SEL_INV_PORT1    = 3'h5;
  localparam logic [2:0]  SEL_DIR_PORT0    = 3'h6;
  localparam logic [2:0]  SEL_DIR_PORT1    = 3'h7;
  localparam logic [1:0]  KIND_INPUT       = 2'h0;
  localparam logic [1:0]  KIND_LATCH       = 2'h1;
  localparam logic [1:0]  KIND_INVERT      = 2'h2;
  localparam logic [1:0]  KIND_DIR         = 2'h3;
  localparam logic [7:0]  LATCH_RESET      = 8'hff;
  localparam logic [7:0]  INVERT_RESET     = 8'h00;
  localparam logic [7:0]  DIR_RESET        = 8'hff;
  localparam logic [7:0]  POINTER_RESET    = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_CMD,
    ST_ACK_CMD,
    ST_WDATA,
    ST_ACK_WDATA,
    ST_RDATA,
    ST_HOST_ACK
  } iox_state_type;
endpackage : iox_pkg
`default_nettype wire

// >>> iox_port_if.sv
// Purpose: Carries register writes and register contents between the serial core and one port.
// Assumes: Write strobes are one core_clk cycle wide.
// Notes:   The ctl side writes, the port side holds the registers.
`timescale 1ns/1ps
`default_nettype none
interface iox_port_if #(parameter int W = 8);
  logic         wrLatch;
  logic         wrInvert;
  logic         wrDir;
  logic [W-1:0] wrData;
  logic [W-1:0] level;
  logic [W-1:0] latch;
  logic [W-1:0] invert;
  logic [W-1:0] dir;

  modport ctl  (output wrLatch, wrInvert, wrDir, wrData, input level, latch, invert, dir);
  modport port (input wrLatch, wrInvert, wrDir, wrData, output level, latch, invert, dir);
endinterface : iox_port_if
`default_nettype wire

// >>> iox_gpio_port.sv
// Purpose: One eight-pin port: output latch, inversion, direction and sensed level.
// Assumes: Pin inputs are asynchronous and pass two flip-flops before use.
// Notes:   Pin drive is a registered copy of the latch; enable is the registered inverse of direction.
`timescale 1ns/1ps
`default_nettype none
module iox_gpio_port
  import iox_pkg::*;
#(
  parameter int W = PORT_WIDTH
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // Register side.
  iox_port_if.port          regs,
  // Pins.
  input  wire logic [W-1:0] pinIn,
  output var  logic [W-1:0] pinOut,
  output var  logic [W-1:0] pinOe
);
  logic [W-1:0] pinMeta;
  logic [W-1:0] pinSync;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regs.latch  <= LATCH_RESET;
      regs.invert <= INVERT_RESET;
      regs.dir    <= DIR_RESET;
    end else begin
      if (regs.wrLatch) begin
        regs.latch <= regs.wrData;
      end
      if (regs.wrInvert) begin
        regs.invert <= regs.wrData;
      end
      if (regs.wrDir) begin
        regs.dir <= regs.wrData;
      end
    end
  end

  // Sensed level follows the pins whatever the direction, with inversion applied.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regs.level <= '0;
    end else begin
      regs.level <= pinSync ^ regs.invert;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinOut <= LATCH_RESET;
      pinOe  <= '0;
    end else begin
      pinOut <= regs.latch;
      pinOe  <= ~regs.dir;
    end
  end
endmodule : iox_gpio_port
`default_nettype wire

// >>> iox_expander.sv
// Purpose: Serial-bus target with a command pointer and two eight-pin I/O ports.
// Assumes: SCL and SDA are open-drain bus lines sampled by core_clk at 200 MHz.
// Notes:   SDA is driven low only; its output enable is high while pulling low.
`timescale 1ns/1ps
`default_nettype none
module iox_expander
  import iox_pkg::*;
#(
  parameter int W = PORT_WIDTH
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // Serial bus.
  input  wire logic         sclIn,
  input  wire logic         sdaIn,
  output var  logic         sdaOut,
  output var  logic         sdaOe,
  // Address straps.
  input  wire logic         addrStrap0,
  input  wire logic         addrStrap1,
  input  wire logic         addrStrap2,
  // Port 0 pins.
  input  wire logic [W-1:0] port0PinsIn,
  output var  logic [W-1:0] port0PinsOut,
  output var  logic [W-1:0] port0PinsOe,
  // Port 1 pins.
  input  wire logic [W-1:0] port1PinsIn,
  output var  logic [W-1:0] port1PinsOut,
  output var  logic [W-1:0] port1PinsOe
);
  iox_port_if #(.W(W)) port0Bus ();
  iox_port_if #(.W(W)) port1Bus ();

  logic [1:0]    sclMeta;
  logic [1:0]    sdaMeta;
  logic [2:0]    strapMeta;
  logic [2:0]    strapSync;
  logic          sclSync;
  logic          sdaSync;
  logic          sclLast;
  logic          sdaLast;
  logic          sclRise;
  logic          sclFall;
  logic          startSeen;
  logic          stopSeen;
  iox_state_type state;
  logic [3:0]    bitCnt;
  logic [7:0]    rxShift;
  logic [7:0]    txShift;
  logic [7:0]    pointer;
  logic [2:0]    accessSel;
  logic [7:0]    readData;
  logic          addrMatch;
  logic          wrPulse;
  logic [2:0]    wrSel;
  logic [7:0]    wrByte;

  // Two-stage synchronisers for the bus lines and straps.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclMeta   <= 2'h3;
      sdaMeta   <= 2'h3;
      strapMeta <= 3'h0;
      strapSync <= 3'h0;
    end else begin
      sclMeta   <= {sclMeta[0], sclIn};
      sdaMeta   <= {sdaMeta[0], sdaIn};
      strapMeta <= {addrStrap2, addrStrap1, addrStrap0};
      strapSync <= strapMeta;
    end
  end

  assign sclSync = sclMeta[1];
  assign sdaSync = sdaMeta[1];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end else begin
      sclLast <= sclSync;
      sdaLast <= sdaSync;
    end
  end

  assign sclRise   = sclSync & ~sclLast;
  assign sclFall   = ~sclSync & sclLast;
  assign startSeen = sclSync & sclLast & sdaLast & ~sdaSync;
  assign stopSeen  = sclSync & sclLast & ~sdaLast & sdaSync;
  assign addrMatch = (rxShift[7:1] == {TARGET_PREFIX, strapSync});

  // Read multiplexer: kind from the upper select bits, port from bit zero.
  always_comb begin
    readData = 8'h00;
    case (accessSel[2:1])
      KIND_INPUT:  readData = accessSel[0] ? port1Bus.level  : port0Bus.level;
      KIND_LATCH:  readData = accessSel[0] ? port1Bus.latch  : port0Bus.latch;
      KIND_INVERT: readData = accessSel[0] ? port1Bus.invert : port0Bus.invert;
      KIND_DIR:    readData = accessSel[0] ? port1Bus.dir    : port0Bus.dir;
      default:     readData = 8'h00;
    endcase
  end

  // Serial state machine, bit counter and shift registers.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state   <= ST_IDLE;
      bitCnt  <= 4'h0;
      rxShift <= 8'h00;
      txShift <= 8'h00;
      sdaOe   <= 1'b0;
    end else if (stopSeen) begin
      state <= ST_IDLE;
      sdaOe <= 1'b0;
    end else if (startSeen) begin
      state  <= ST_ADDR;
      bitCnt <= 4'h0;
      sdaOe  <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (sclRise && bitCnt != BITS_PER_BYTE) begin
            rxShift <= {rxShift[6:0], sdaSync};
            bitCnt  <= bitCnt + 4'h1;
          end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
            bitCnt <= 4'h0;
            if (state == ST_ADDR) begin
              if (addrMatch) begin
                state <= ST_ACK_ADDR;
                sdaOe <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end else if (state == ST_CMD) begin
              state <= ST_ACK_CMD;
              sdaOe <= 1'b1;
            end else begin
              state <= ST_ACK_WDATA;
              sdaOe <= 1'b1;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (sclFall) begin
            if (rxShift[0]) begin
              state   <= ST_RDATA;
              txShift <= readData;
              sdaOe   <= ~readData[7];
            end else begin
              state <= ST_CMD;
              sdaOe <= 1'b0;
            end
          end
        end
        ST_ACK_CMD, ST_ACK_WDATA: begin
          if (sclFall) begin
            state <= ST_WDATA;
            sdaOe <= 1'b0;
          end
        end
        ST_RDATA: begin
          if (sclFall) begin
            if (bitCnt == BITS_PER_BYTE - 4'h1) begin
              bitCnt <= 4'h0;
              state  <= ST_HOST_ACK;
              sdaOe  <= 1'b0;
            end else begin
              bitCnt  <= bitCnt + 4'h1;
              txShift <= {txShift[6:0], 1'b0};
              sdaOe   <= ~txShift[6];
            end
          end
        end
        ST_HOST_ACK: begin
          if (sclRise && sdaSync) begin
            state <= ST_IDLE;
          end else if (sclFall) begin
            state   <= ST_RDATA;
            txShift <= readData;
            sdaOe   <= ~readData[7];
          end
        end
        default: begin
          state <= ST_IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // The bus is open-drain: the pad only ever pulls low.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  // Command pointer and the register currently being accessed.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pointer   <= POINTER_RESET;
      accessSel <= POINTER_RESET[2:0];
    end else if (startSeen) begin
      if (state != ST_IDLE) begin
        pointer[2:0] <= accessSel;
      end else begin
        accessSel <= pointer[2:0];
      end
    end else if (sclRise && state == ST_ACK_CMD) begin
      pointer   <= rxShift;
      accessSel <= rxShift[2:0];
    end else if (sclRise && state == ST_ACK_WDATA) begin
      accessSel <= {accessSel[2:1], ~accessSel[0]};
    end else if (sclRise && state == ST_HOST_ACK && !sdaSync) begin
      accessSel <= {accessSel[2:1], ~accessSel[0]};
    end
  end

  // Data bytes are committed on the rising edge of their acknowledge clock.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wrPulse <= 1'b0;
      wrSel   <= 3'h0;
      wrByte  <= 8'h00;
    end else begin
      wrPulse <= sclRise && state == ST_ACK_WDATA && !startSeen && !stopSeen;
      if (sclRise && state == ST_ACK_WDATA) begin
        wrSel  <= accessSel;
        wrByte <= rxShift;
      end
    end
  end

  // Write strobes toward the ports; input registers take no writes.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      port0Bus.wrLatch  <= 1'b0;
      port0Bus.wrInvert <= 1'b0;
      port0Bus.wrDir    <= 1'b0;
      port1Bus.wrLatch  <= 1'b0;
      port1Bus.wrInvert <= 1'b0;
      port1Bus.wrDir    <= 1'b0;
      port0Bus.wrData   <= 8'h00;
      port1Bus.wrData   <= 8'h00;
    end else begin
      port0Bus.wrLatch  <= wrPulse && wrSel == SEL_OUT_PORT0;
      port1Bus.wrLatch  <= wrPulse && wrSel == SEL_OUT_PORT1;
      port0Bus.wrInvert <= wrPulse && wrSel == SEL_INV_PORT0;
      port1Bus.wrInvert <= wrPulse && wrSel == SEL_INV_PORT1;
      port0Bus.wrDir    <= wrPulse && wrSel == SEL_DIR_PORT0;
      port1Bus.wrDir    <= wrPulse && wrSel == SEL_DIR_PORT1;
      port0Bus.wrData   <= wrByte;
      port1Bus.wrData   <= wrByte;
    end
  end

  iox_gpio_port #(.W(W)) port0Inst (
    .core_clk (core_clk),
    .nrst     (nrst),
    .regs     (port0Bus),
    .pinIn    (port0PinsIn),
    .pinOut   (port0PinsOut),
    .pinOe    (port0PinsOe)
  );

  iox_gpio_port #(.W(W)) port1Inst (
    .core_clk (core_clk),
    .nrst     (nrst),
    .regs     (port1Bus),
    .pinIn    (port1PinsIn),
    .pinOut   (port1PinsOut),
    .pinOe    (port1PinsOe)
  );
endmodule : iox_expander
`default_nettype wire

// >>> iox_expander_chk.sv
// Purpose: Port assertions for the serial I/O expander.
// Assumes: SCL phases last ten or more core_clk cycles.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module iox_expander_chk
  import iox_pkg::*;
#(
  parameter int W = PORT_WIDTH
) (
  // Clock, reset and bus.
  input wire logic         core_clk,
  input wire logic         nrst,
  input wire logic         sclIn,
  input wire logic         sdaOut,
  input wire logic         sdaOe,
  // Pins.
  input wire logic [W-1:0] port0PinsOut,
  input wire logic [W-1:0] port0PinsOe,
  input wire logic [W-1:0] port1PinsOut,
  input wire logic [W-1:0] port1PinsOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_RESET_STATE: assert property (
    $rose(nrst) |-> &port0PinsOut && &port1PinsOut && !(|port0PinsOe) && !(|port1PinsOe))
    else $error("pins not at reset state");
  AST_SDA_LOW_ONLY: assert property (
    sdaOe |-> !sdaOut)
    else $error("sda driven high");
  AST_SDA_MOVES_LOW: assert property (
    $changed(sdaOe) |-> !sclIn && !$past(sclIn))
    else $error("sda changed near scl high");
  AST_SDA_HOLDS_HIGH: assert property (
    $rose(sclIn) |=> $stable(sdaOe) [*8])
    else $error("sda moved while scl high");
  AST_P0_OUT_ACK: assert property (
    $changed(port0PinsOut) |-> sclIn && $past(sclIn, 2))
    else $error("port0 output moved outside scl high");
  AST_P1_OE_ACK: assert property (
    $changed(port1PinsOe) |-> sclIn)
    else $error("port1 enable moved outside scl high");
  AST_ONE_REG_P0: assert property (
    $changed(port0PinsOe) |-> $stable(port1PinsOe) && $stable(port0PinsOut))
    else $error("two registers written at once");
  AST_ONE_REG_P1: assert property (
    $changed(port1PinsOut) |-> $stable(port0PinsOut) && $stable(port1PinsOe))
    else $error("two registers written at once");
endmodule : iox_expander_chk
`default_nettype wire

// >>> iox_i2c_host.sv
// Purpose: Bus controller model that bit-bangs SCL and SDA.
// Assumes: SDA is open drain with a pull-up; sdaLow pulls it down.
// Notes:   Every change lands 1 ns after a core_clk edge.
`timescale 1ns/1ps
`default_nettype none
module iox_i2c_host #(
  parameter int HALF = 16
) (
  // Clock.
  input  wire logic core_clk,
  // Bus lines.
  input  wire logic sdaWire,
  output var  logic scl,
  output var  logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : w
  // Data settles in the low phase and is sampled mid high phase.
  task automatic bus_bit(input logic b, output logic r);
    w(2);
    sdaLow = !b;
    w(HALF);
    scl = 1'b1;
    w(HALF / 2);
    r = sdaWire;
    w(HALF / 2);
    scl = 1'b0;
  endtask : bus_bit
  // Also serves as a repeated start, entered with SCL low.
  task automatic start_cond();
    w(2);
    sdaLow = 1'b0;
    w(HALF);
    scl = 1'b1;
    w(HALF);
    sdaLow = 1'b1;
    w(HALF);
    scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    w(2);
    sdaLow = 1'b1;
    w(HALF);
    scl = 1'b1;
    w(HALF);
    sdaLow = 1'b0;
    w(HALF);
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) bus_bit(b[i], nak);
    bus_bit(1'b1, nak);
  endtask : send_byte
  task automatic recv_byte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bus_bit(1'b1, d[i]);
    bus_bit(nak, r);
  endtask : recv_byte
endmodule : iox_i2c_host
`default_nettype wire

// >>> tb_i2c_sixteen_bit_io_expander.sv
// Purpose: Self-checking bench for the serial I/O expander.
// Assumes: Straps read 3'h3 outside the address sweep.
// Notes:   Row table first, then pins, inputs, addresses and reset.
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_sixteen_bit_io_expander import iox_pkg::*;;
  logic        core_clk, sclIn, sdaIn, sdaOut, sdaOe, hostLow;
  logic        nrst = 1'b0;
  logic [2:0]  strap = 3'h3;
  logic [7:0]  p0In = 8'h96, p1In = 8'h5a, p0Out, p0Oe, p1Out, p1Oe, q0, q1;
  int          n_mismatch = 0, compares = 0;
  logic [23:0] rows [9] = '{24'h003c96, 24'h013c5a, 24'h02a5a5, 24'h033c3c, 24'h040f0f,
                            24'h05f0f0, 24'h060000, 24'h075555, 24'h0b5a5a};
  logic [7:0]  rstVal [6] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
  assign sdaIn = !((sdaOe && !sdaOut) || hostLow);
  iox_expander #(.W(PORT_WIDTH)) i_iox_expander (.core_clk(core_clk), .nrst(nrst), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap0(strap[0]), .addrStrap1(strap[1]), .addrStrap2(strap[2]),
    .port0PinsIn(p0In), .port0PinsOut(p0Out), .port0PinsOe(p0Oe), .port1PinsIn(p1In), .port1PinsOut(p1Out),
    .port1PinsOe(p1Oe));
  iox_i2c_host i_iox_i2c_host (.core_clk(core_clk), .sdaWire(sdaIn), .scl(sclIn), .sdaLow(hostLow));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic sb(input logic [7:0] b, input logic expNak);
    logic nak;
    i_iox_i2c_host.send_byte(b, nak);
    check({7'h0, nak}, {7'h0, expNak});
  endtask : sb
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    i_iox_i2c_host.start_cond();
    sb({TARGET_PREFIX, 3'h3, 1'b0}, 1'b0);
    sb(c, 1'b0);
    sb(d, 1'b0);
    i_iox_i2c_host.stop_cond();
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic setPtr);
    if (setPtr) begin
      i_iox_i2c_host.start_cond();
      sb({TARGET_PREFIX, 3'h3, 1'b0}, 1'b0);
      sb(c, 1'b0);
    end
    i_iox_i2c_host.start_cond();
    sb({TARGET_PREFIX, 3'h3, 1'b1}, 1'b0);
    i_iox_i2c_host.recv_byte(1'b0, q0);
    i_iox_i2c_host.recv_byte(1'b1, q1);
    i_iox_i2c_host.stop_cond();
  endtask : rd
  initial begin
    repeat (5) @(posedge core_clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], 1'b1);
      check(q0, rows[i][7:0]);
    end
    check(p0Out, 8'ha5);
    check(p0Oe, 8'hff);
    check(p1Out, 8'h5a);
    check(p1Oe, 8'haa);
    rd(8'h00, 1'b1);
    check(q0, 8'h99);
    check(q1, 8'haa);
    rd(8'h01, 1'b1);
    check(q1, 8'h99);
    rd(8'h00, 1'b0);
    check(q0, 8'haa);
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      i_iox_i2c_host.start_cond();
      sb({TARGET_PREFIX, 3'(s) ^ 3'h4, 1'b0}, 1'b1);
      i_iox_i2c_host.start_cond();
      sb({TARGET_PREFIX, 3'(s), 1'b1}, 1'b0);
      i_iox_i2c_host.recv_byte(1'b1, q0);
      i_iox_i2c_host.stop_cond();
      check(q0, 8'haa);
    end
    strap = 3'h3;
    p0In = 8'h3c;
    rd(8'h00, 1'b1);
    check(q0, 8'h33);
    // Repeated start after a latch write repoints to the other latch of the pair.
    i_iox_i2c_host.start_cond();
    sb({TARGET_PREFIX, 3'h3, 1'b0}, 1'b0);
    sb(8'h02, 1'b0);
    sb(8'h77, 1'b0);
    i_iox_i2c_host.start_cond();
    sb({TARGET_PREFIX, 3'h3, 1'b1}, 1'b0);
    i_iox_i2c_host.recv_byte(1'b1, q0);
    i_iox_i2c_host.stop_cond();
    check(q0, 8'h5a);
    check(p0Out, 8'h77);
    rd(8'h00, 1'b0);
    check(q0, 8'h5a);
    check(q1, 8'h77);
    nrst = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 nrst = 1'b1;
    check(p0Oe, 8'h00);
    check(p1Out, 8'hff);
    repeat (3) @(posedge core_clk);
    for (int r = 0; r < 6; r++) begin
      rd(8'(r + 2), 1'b1);
      check(q0, rstVal[r]);
    end
    end_sim();
  end
  initial begin
    #400us;
    n_mismatch++;
    end_sim();
  end
endmodule : tb_i2c_sixteen_bit_io_expander
bind iox_expander iox_expander_chk #(.W(W)) i_iox_expander_chk (.core_clk(core_clk), .nrst(nrst), .sclIn(sclIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .port0PinsOut(port0PinsOut), .port0PinsOe(port0PinsOe),
  .port1PinsOut(port1PinsOut), .port1PinsOe(port1PinsOe));
`default_nettype wire
